// [core/borl_pkg.sv]
// Package of constants for the binary output relay conditioning logic
// Operation
// - Each of up to seven assigned signals has its own inversion, default inactive.
// - Relay output holds each new state at least the hold time, 0-300 s.
// - With latching active, a picked-up output stays up after the drive drops.
// - A selectable acknowledgement signal releases the latched state of the relay.
// - Acknowledgement is ignored whenever latching is inactive.
// - Acknowledgement selection is only configurable while latching is active.
// - Output inversion flips the final relay state after all other processing.
package borl_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned TICK_US         = 10_000;
  localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TIME_MAX_CS     = 30_000;
  localparam int unsigned TIME_W          = 15;
  localparam logic [14:0] HOLD_RESET_CS   = 15'h0000;
  localparam logic [14:0] OFFDLY_RESET_CS = 15'h0000;
  localparam int unsigned NUM_ASSIGN      = 7;
  localparam int unsigned SEL_W           = 3;
  // ----------------------------------------------------------------
  // Output state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF     = 3'b001,
    ST_ON      = 3'b010,
    ST_OFF_DLY = 3'b100
  } borl_state_e;

  function automatic logic [14:0] clamp_cs(input logic [14:0] v);
    clamp_cs = (v > 15'(TIME_MAX_CS)) ? 15'(TIME_MAX_CS) : v;
  endfunction : clamp_cs
endpackage : borl_pkg

// [core/borl_relay.sv]
// Conditioning logic for one binary output relay channel
module borl_relay
  import borl_pkg::*;
#(
  parameter int unsigned N_ASSIGN = NUM_ASSIGN,
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  input  wire logic [N_ASSIGN-1:0] i_assign,
  input  wire logic [N_ASSIGN-1:0] i_assign_used,
  input  wire logic [N_ASSIGN-1:0] i_assign_invert,
  input  wire logic                i_latch_en,
  input  wire logic                i_ack,
  input  wire logic                i_out_invert,
  input  wire logic [TIME_W-1:0]   i_hold_cs,
  input  wire logic [TIME_W-1:0]   i_off_delay_cs,
  output logic                     o_relay,
  output logic                     o_latched,
  output logic                     o_ack_cfg_en
);
  initial begin
    if (N_ASSIGN < 1 || N_ASSIGN > NUM_ASSIGN) $error("borl_relay: N_ASSIGN out of range");
  end

  // ----------------------------------------------------------------
  // Input synchronisers: assigned signals may come from other logic
  // ----------------------------------------------------------------
  logic [N_ASSIGN-1:0] asg_s1;
  logic [N_ASSIGN-1:0] asg_s2;
  logic                ack_s1;
  logic                ack_s2;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      asg_s1 <= '0;
      asg_s2 <= '0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      asg_s1 <= i_assign;
      asg_s2 <= asg_s1;
      ack_s1 <= i_ack;
      ack_s2 <= ack_s1;
    end
  end

  // ----------------------------------------------------------------
  // Combination of assigned signals
  // ----------------------------------------------------------------
  // Unused slots are masked off; the used, per-slot inverted signals are ORed
  logic drive;
  assign drive = |((asg_s2 ^ i_assign_invert) & i_assign_used);

  // ----------------------------------------------------------------
  // Latch
  // ----------------------------------------------------------------
  logic ack_eff;
  assign ack_eff      = i_latch_en & ack_s2;
  assign o_ack_cfg_en = i_latch_en;

  logic latch_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      latch_q <= 1'b0;
    end else if (!i_latch_en) begin
      latch_q <= 1'b0;
    end else if (drive) begin
      latch_q <= 1'b1;
    end else if (ack_eff) begin
      latch_q <= 1'b0;
    end
  end
  // Acknowledge only releases once the drive itself has dropped
  assign o_latched = latch_q;

  logic want_on;
  assign want_on = drive | latch_q;

  // ----------------------------------------------------------------
  // Time base and counters (hundredths of a second)
  // ----------------------------------------------------------------
  logic tick;

  borl_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .o_tick    (tick)
  );

  logic [TIME_W-1:0] hold_cnt;
  logic [TIME_W-1:0] off_cnt;
  logic              hold_done;
  logic              load_hold;
  assign hold_done = (hold_cnt == '0);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_cnt <= HOLD_RESET_CS;
    end else if (load_hold) begin
      // Rounds up: the partial tick in progress is not counted
      hold_cnt <= (clamp_cs(i_hold_cs) == '0) ? '0 : clamp_cs(i_hold_cs) + 15'h0001;
    end else if (tick && !hold_done) begin
      hold_cnt <= hold_cnt - 15'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Output state machine
  // ----------------------------------------------------------------
  borl_state_e state;
  logic        state_on;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state   <= ST_OFF;
      off_cnt <= OFFDLY_RESET_CS;
    end else begin
      unique case (state)
        ST_OFF: begin
          if (want_on && hold_done) begin
            state <= ST_ON;
          end
        end
        ST_ON: begin
          if (!want_on && hold_done) begin
            if (clamp_cs(i_off_delay_cs) == '0) begin
              state <= ST_OFF;
            end else begin
              off_cnt <= clamp_cs(i_off_delay_cs);
              state   <= ST_OFF_DLY;
            end
          end
        end
        ST_OFF_DLY: begin
          if (want_on) begin
            state <= ST_ON;
          end else if (tick) begin
            if (off_cnt == 15'h0001) begin
              state <= ST_OFF;
            end
            off_cnt <= off_cnt - 15'h0001;
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  assign state_on  = (state != ST_OFF);
  // A change of the relay state restarts the minimum hold
  assign load_hold = (state == ST_OFF && want_on && hold_done) ||
                     (state_on && !want_on && hold_done &&
                      clamp_cs(i_off_delay_cs) == '0 && state == ST_ON) ||
                     (state == ST_OFF_DLY && !want_on && tick && off_cnt == 15'h0001);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_relay <= 1'b0;
    end else begin
      o_relay <= state_on ^ i_out_invert;
    end
  end
endmodule : borl_relay

// [core/borl_tick.sv]
// Divider producing a one-cycle enable every hundredth of a second
module borl_tick
  import borl_pkg::*;
#(
  parameter int unsigned DIV = TICK_CYCLES
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  output logic      o_tick
);
  initial begin
    if (DIV < 1) $error("borl_tick: DIV must be at least 1");
  end

  logic [31:0] cnt;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt    <= 32'h0000_0000;
      o_tick <= 1'b0;
    end else if (cnt >= 32'(DIV - 1)) begin
      cnt    <= 32'h0000_0000;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 32'h0000_0001;
      o_tick <= 1'b0;
    end
  end
endmodule : borl_tick

// [tb/borl_relay_checker.sv]
// Assertion checker for the binary output relay conditioning logic
module borl_relay_checker
  import borl_pkg::*;
#(
  parameter int unsigned N_ASSIGN = NUM_ASSIGN,
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input wire logic                i_ref_clk,
  input wire logic                i_rst,
  input wire logic [N_ASSIGN-1:0] i_assign,
  input wire logic [N_ASSIGN-1:0] i_assign_used,
  input wire logic [N_ASSIGN-1:0] i_assign_invert,
  input wire logic                i_latch_en,
  input wire logic                i_ack,
  input wire logic                i_out_invert,
  input wire logic [TIME_W-1:0]   i_hold_cs,
  input wire logic [TIME_W-1:0]   i_off_delay_cs,
  input wire logic                o_relay,
  input wire logic                o_latched,
  input wire logic                o_ack_cfg_en
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic       drv;
  logic [7:0] low_cnt;
  assign drv = |(i_assign_used & (i_assign ^ i_assign_invert));
  // Saturates so a long idle spell cannot wrap back under the bound
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst || drv) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end
  ack_cfg_a: assert property (o_ack_cfg_en == i_latch_en)
    else $error("ack select enable wrong");
  latch_off_a: assert property (!$past(i_latch_en) |-> !o_latched)
    else $error("latched while latching off");
  latch_keep_a: assert property (o_latched && $past(o_latched) && $stable(i_out_invert)
    |-> o_relay != i_out_invert) else $error("latched relay not picked up");
  on_time_a: assert property ($rose(drv) && i_hold_cs == 15'h0000 ##1 drv[*2]
    |-> ##[2:4] o_relay != i_out_invert) else $error("relay late to pick up");
  off_dly_a: assert property ($fell(o_relay) && !i_out_invert
    && i_off_delay_cs == 15'h0003 |-> low_cnt >= 8'h0A) else $error("off delay short");
  hold_a: assert property ($changed(o_relay) && i_hold_cs == 15'h0002
    |=> $stable(o_relay)[*7]) else $error("hold time short");
  ack_rel_a: assert property ((i_latch_en && i_ack && !drv)[*5] |-> !o_latched)
    else $error("ack did not release");
  out_inv_a: assert property ($changed(i_out_invert) && o_latched && $past(o_latched)
    |=> $changed(o_relay)) else $error("output inversion ignored");
  cover property ($rose(o_latched));
  cover property ($fell(o_latched));
  cover property ($fell(o_relay) && i_off_delay_cs == 15'h0003);
endmodule : borl_relay_checker

bind borl_relay borl_relay_checker #(.N_ASSIGN(N_ASSIGN), .TICK_DIV(TICK_DIV)) u_chk (
  .i_ref_clk, .i_rst, .i_assign, .i_assign_used, .i_assign_invert, .i_latch_en, .i_ack,
  .i_out_invert, .i_hold_cs, .i_off_delay_cs, .o_relay, .o_latched, .o_ack_cfg_en);

// [tb/borl_relay_tb_top.sv]
// Testbench for the binary output relay conditioning logic
module borl_relay_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, lat = 1'b0, ack = 1'b0, oinv = 1'b0;
  logic        relay, latched, cfg;
  logic [6:0]  asg = 7'h00, used = 7'h7F, ainv = 7'h00;
  logic [14:0] hold = 15'h0000, offd = 15'h0000;
  int          mismatches = 0, cmp_count = 0;
  // Short tick keeps the hold and off-delay counts to a few cycles
  borl_relay #(.TICK_DIV(4)) dut (.i_ref_clk(clk), .i_rst(rst), .i_assign(asg),
    .i_assign_used(used), .i_assign_invert(ainv), .i_latch_en(lat), .i_ack(ack),
    .i_out_invert(oinv), .i_hold_cs(hold), .i_off_delay_cs(offd), .o_relay(relay),
    .o_latched(latched), .o_ack_cfg_en(cfg));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(string nm, logic exp, logic got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s exp %b got %b", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    // Step off the edge so registered outputs are settled when read
    #1;
  endtask : cyc
  task automatic wait_rel(logic exp, int lim);
    int n;
    n = 0;
    while (relay !== exp && n < lim) begin
      cyc(1);
      #1;
      n++;
    end
    chk("relay", exp, relay);
    if (n == lim) conclude();
  endtask : wait_rel
  initial begin
    cyc(5);
    rst <= 1'b0;
    cyc(1);
    #1;
    chk("cfg", 1'b0, cfg);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk) asg <= 7'h01 << i;
      wait_rel(1'b1, 10);
      @(posedge clk) asg <= 7'h00;
      wait_rel(1'b0, 10);
    end
    @(posedge clk) ainv <= 7'h40;
    wait_rel(1'b1, 10);
    @(posedge clk) ainv <= 7'h00;
    wait_rel(1'b0, 10);
    @(posedge clk) hold <= 15'h0002;
    asg <= 7'h01;
    @(posedge clk) asg <= 7'h00;
    wait_rel(1'b1, 10);
    cyc(5);
    chk("relay", 1'b1, relay);
    wait_rel(1'b0, 30);
    // The switch-off reloads the hold; let it lapse before the next pick-up
    cyc(15);
    @(posedge clk) hold <= 15'h0000;
    offd <= 15'h0003;
    asg <= 7'h02;
    wait_rel(1'b1, 10);
    @(posedge clk) asg <= 7'h00;
    cyc(8);
    chk("relay", 1'b1, relay);
    wait_rel(1'b0, 30);
    @(posedge clk) offd <= 15'h0000;
    lat <= 1'b1;
    asg <= 7'h04;
    wait_rel(1'b1, 10);
    @(posedge clk) asg <= 7'h00;
    cyc(20);
    chk("relay", 1'b1, relay);
    chk("cfg", 1'b1, cfg);
    @(posedge clk) oinv <= 1'b1;
    cyc(3);
    chk("relay", 1'b0, relay);
    @(posedge clk) oinv <= 1'b0;
    asg <= 7'h04;
    ack <= 1'b1;
    cyc(8);
    chk("latched", 1'b1, latched);
    @(posedge clk) asg <= 7'h00;
    wait_rel(1'b0, 20);
    @(posedge clk) ack <= 1'b0;
    asg <= 7'h08;
    wait_rel(1'b1, 10);
    @(posedge clk) asg <= 7'h00;
    lat <= 1'b0;
    ack <= 1'b1;
    wait_rel(1'b0, 20);
    chk("latched", 1'b0, latched);
    conclude();
  end
endmodule : borl_relay_tb_top
